/* File: sra_pkg.sv */
// shared constants and types for the special register area
package sra_pkg;

	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int LOW_BYTE_W = 8;

	// ----------------------------------------------------------------
	// data memory map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] IAP_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] PTR_ADDR = 8'h01;
	localparam logic [ADDR_W-1:0] ACC_ADDR = 8'h05;
	localparam logic [ADDR_W-1:0] PCL_ADDR = 8'h06;
	localparam logic [ADDR_W-1:0] TABLE_READ_POINTER_ADDR = 8'h07;
	localparam logic [ADDR_W-1:0] TABLE_READ_HIGH_BYTE_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] GP_BASE = 8'h40;
	localparam int GP_DEPTH = 256 - 64;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rd;
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} dm_req_t;

	typedef enum logic [0:0] {
		TBL_IDLE = 1'b0,
		TBL_STORE = 1'b1
	} tbl_state_t;

endpackage

/* File: special_register_access.sv */
// special-purpose register area of the data memory, with general RAM behind it
`timescale 1ns/1ns
`default_nettype none
module special_register_access
	import sra_pkg::*;
#(
	parameter int PC_W = 11,
	parameter int ROM_W = 14
) (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire dm_req_t DM_REQ,
	input wire logic ALU_WE,
	input wire logic [DATA_W-1:0] ALU_RESULT,
	input wire logic PC_STEP,
	input wire logic TBL_RD,
	input wire logic [ADDR_W-1:0] TBL_DEST,
	input wire logic [ROM_W-1:0] ROM_DATA,
	output logic [DATA_W-1:0] DM_RDATA,
	output logic DM_RVALID,
	output logic [DATA_W-1:0] ACC,
	output logic [PC_W-1:0] PC,
	output logic DUMMY_CYCLE,
	output logic [PC_W-1:0] TBL_ADDR,
	output logic TBL_BUSY
);

	localparam int HI_W = ROM_W - LOW_BYTE_W;

	// ----------------------------------------------------------------
	// address resolution
	// ----------------------------------------------------------------
	function automatic logic [ADDR_W-1:0] resolve(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ptr);
		return (a == IAP_ADDR) ? ptr : a;
	endfunction

	function automatic logic [ADDR_W-1:0] gp_index(input logic [ADDR_W-1:0] a);
		return a - GP_BASE;
	endfunction

	logic [DATA_W-1:0] mp_r;
	logic [DATA_W-1:0] acc_r;
	logic [PC_W-1:0] pc_r;
	logic [DATA_W-1:0] table_read_pointer_r;
	logic [DATA_W-1:0] table_read_high_byte_r;
	logic [ADDR_W-1:0] dest_r;
	logic [PC_W-1:0] tbl_addr_r;
	logic busy_r;
	logic dummy_r;
	logic [DATA_W-1:0] rdata_r;
	logic rvalid_r;
	tbl_state_t state_r;
	logic [DATA_W-1:0] ram [GP_DEPTH];

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire [ADDR_W-1:0] rd_addr = resolve(DM_REQ.addr, mp_r);
	wire rd_gp = rd_addr >= GP_BASE;
	wire rd_unused = !rd_gp && rd_addr != PTR_ADDR && rd_addr != ACC_ADDR &&
		rd_addr != PCL_ADDR && rd_addr != TABLE_READ_POINTER_ADDR && rd_addr != TABLE_READ_HIGH_BYTE_ADDR;
	// the port itself decodes as unused: no storage, reads zero
	wire [DATA_W-1:0] rd_sel =
		(rd_addr == PTR_ADDR) ? mp_r :
		(rd_addr == ACC_ADDR) ? acc_r :
		(rd_addr == PCL_ADDR) ? pc_r[LOW_BYTE_W-1:0] :
		(rd_addr == TABLE_READ_POINTER_ADDR) ? table_read_pointer_r :
		(rd_addr == TABLE_READ_HIGH_BYTE_ADDR) ? table_read_high_byte_r :
		rd_gp ? ram[gp_index(rd_addr)] : ZERO_BYTE;

	// ----------------------------------------------------------------
	// write path: table store outranks a core write in the same cycle
	// ----------------------------------------------------------------
	wire tbl_store = busy_r;
	wire wr_en = tbl_store || DM_REQ.wr;
	wire [ADDR_W-1:0] wr_addr = tbl_store ? resolve(dest_r, mp_r) : resolve(DM_REQ.addr, mp_r);
	// write data only ever comes from the core bus or the rom word
	wire [DATA_W-1:0] wr_data = tbl_store ? ROM_DATA[LOW_BYTE_W-1:0] : DM_REQ.wdata;
	wire wr_ok = wr_en && wr_addr != IAP_ADDR;
	wire wr_mp = wr_ok && wr_addr == PTR_ADDR;
	wire wr_acc = wr_ok && wr_addr == ACC_ADDR;
	wire wr_pcl = wr_ok && wr_addr == PCL_ADDR;
	wire wr_table_read_pointer = wr_ok && wr_addr == TABLE_READ_POINTER_ADDR;
	wire wr_gp = wr_ok && wr_addr >= GP_BASE;
	wire [DATA_W-1:0] rom_hi = {{(DATA_W-HI_W){1'b0}}, ROM_DATA[ROM_W-1:LOW_BYTE_W]};

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	wire [DATA_W-1:0] mp_nxt = wr_mp ? wr_data : mp_r;
	// alu result wins over a bus write to the accumulator
	wire [DATA_W-1:0] acc_nxt = ALU_WE ? ALU_RESULT : wr_acc ? wr_data : acc_r;
	// the fetch behind a pcl write is stale, so the step is held off for one cycle
	wire [PC_W-1:0] pc_nxt =
		wr_pcl ? {pc_r[PC_W-1:LOW_BYTE_W], wr_data} :
		(PC_STEP && !dummy_r) ? PC_W'(pc_r + 1'b1) : pc_r;
	wire tbl_start = TBL_RD && state_r == TBL_IDLE;
	wire [PC_W-1:0] tbl_addr_nxt = tbl_start ? {pc_r[PC_W-1:LOW_BYTE_W], table_read_pointer_r} :
		tbl_addr_r;
	wire [DATA_W-1:0] table_read_high_byte_nxt = tbl_store ? rom_hi : table_read_high_byte_r;
	wire [DATA_W-1:0] table_read_pointer_nxt = wr_table_read_pointer ? wr_data : table_read_pointer_r;
	wire tbl_state_t state_nxt = tbl_start ? TBL_STORE : TBL_IDLE;

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mp_r <= ZERO_BYTE;
			acc_r <= ZERO_BYTE;
			pc_r <= '0;
			table_read_pointer_r <= ZERO_BYTE;
			table_read_high_byte_r <= ZERO_BYTE;
			dest_r <= IAP_ADDR;
			tbl_addr_r <= '0;
			state_r <= TBL_IDLE;
			busy_r <= 1'b0;
			dummy_r <= 1'b0;
			rdata_r <= ZERO_BYTE;
			rvalid_r <= 1'b0;
		end else begin
			mp_r <= mp_nxt;
			acc_r <= acc_nxt;
			pc_r <= pc_nxt;
			table_read_pointer_r <= table_read_pointer_nxt;
			table_read_high_byte_r <= table_read_high_byte_nxt;
			dest_r <= tbl_start ? TBL_DEST : dest_r;
			tbl_addr_r <= tbl_addr_nxt;
			state_r <= state_nxt;
			busy_r <= tbl_start;
			dummy_r <= wr_pcl;
			rdata_r <= DM_REQ.rd ? rd_sel : rdata_r;
			rvalid_r <= DM_REQ.rd;
		end
	end

	// general ram has no reset; software clears it
	always_ff @(posedge REF_CLK) begin
		if (wr_gp) begin
			ram[gp_index(wr_addr)] <= wr_data;
		end
	end

	assign DM_RDATA = rdata_r;
	assign DM_RVALID = rvalid_r;
	assign ACC = acc_r;
	assign PC = pc_r;
	assign DUMMY_CYCLE = dummy_r;
	assign TBL_ADDR = tbl_addr_r;
	assign TBL_BUSY = busy_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	unused_zero_a: assert property (
		DM_REQ.rd && rd_unused |=> DM_RDATA == ZERO_BYTE)
		else $error("unused location did not read zero");
	iap_null_read_a: assert property (
		DM_REQ.rd && DM_REQ.addr == IAP_ADDR && mp_r == IAP_ADDR |=> DM_RDATA == ZERO_BYTE)
		else $error("self-indirect read not zero");
	iap_null_write_a: assert property (
		DM_REQ.wr && !busy_r && DM_REQ.addr == IAP_ADDR && mp_r == IAP_ADDR
		|=> $stable(mp_r) && $stable(table_read_pointer_r))
		else $error("self-indirect write changed state");
	indirect_read_a: assert property (
		DM_REQ.rd && DM_REQ.addr == IAP_ADDR && mp_r == TABLE_READ_POINTER_ADDR
		|=> DM_RDATA == $past(table_read_pointer_r))
		else $error("indirect read missed pointer target");
	mp_write_a: assert property (
		DM_REQ.wr && !busy_r && DM_REQ.addr == PTR_ADDR |=> mp_r == $past(DM_REQ.wdata))
		else $error("pointer write lost");
	acc_alu_a: assert property (
		ALU_WE |=> ACC == $past(ALU_RESULT))
		else $error("alu result not in accumulator");
	pcl_jump_a: assert property (
		wr_pcl |=> PC[LOW_BYTE_W-1:0] == $past(wr_data) &&
		PC[PC_W-1:LOW_BYTE_W] == $past(pc_r[PC_W-1:LOW_BYTE_W]))
		else $error("pcl jump left page or wrong byte");
	dummy_cycle_a: assert property (
		wr_pcl ##1 !wr_pcl |-> DUMMY_CYCLE ##1 ($past(PC) == PC && !DUMMY_CYCLE))
		else $error("dummy cycle missing or pc moved");
	tbl_addr_a: assert property (
		tbl_start |=> TBL_BUSY && TBL_ADDR[LOW_BYTE_W-1:0] == $past(table_read_pointer_r) ##1 !TBL_BUSY)
		else $error("table address not from pointer");
	table_read_high_byte_load_a: assert property (
		TBL_BUSY |=> table_read_high_byte_r == $past(rom_hi))
		else $error("table high byte not stored");
	tbl_low_a: assert property (
		TBL_BUSY && resolve(dest_r, mp_r) == TABLE_READ_POINTER_ADDR |=> table_read_pointer_r == $past(ROM_DATA[7:0]))
		else $error("table low byte not stored");

endmodule
`default_nettype wire

/* File: sra_rom_model.sv */
// program memory model feeding table reads
`timescale 1ns/1ns
`default_nettype none
module sra_rom_model #(
	parameter int PC_W = 11,
	parameter int ROM_W = 14
) (
	input wire logic [PC_W-1:0] addr,
	input wire logic busy,
	output logic [ROM_W-1:0] data
);
	logic [ROM_W-1:0] word;
	// word is a plain function of the table address low byte, so low-byte mis-addressing shows
	assign word = {addr[5:0], addr[7:0]} ^ 14'h2A5C;
	// outside the store cycle the word is inverted, so late sampling is caught
	assign data = busy ? word : ~word;
endmodule
`default_nettype wire

/* File: test_special_register_access.sv */
// self-checking testbench for the special register area
`timescale 1ns/1ns
`default_nettype none
module test_special_register_access
	import sra_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dm_req_t req = '0;
	logic alu_we = 1'b0;
	logic [7:0] alu_res = 8'h00;
	logic pc_step = 1'b0;
	logic tbl_rd = 1'b0;
	logic [7:0] tbl_dest = 8'h00;
	logic [13:0] rom;
	logic [7:0] rdata;
	logic rvalid;
	logic [7:0] acc;
	logic [10:0] pc;
	logic dummy;
	logic [10:0] tbl_addr;
	logic tbl_busy;
	int errors = 0;
	int checked = 0;
	special_register_access #(.PC_W(11), .ROM_W(14)) i_dut (.REF_CLK(clk), .RST(rst),
		.DM_REQ(req), .ALU_WE(alu_we), .ALU_RESULT(alu_res), .PC_STEP(pc_step),
		.TBL_RD(tbl_rd), .TBL_DEST(tbl_dest), .ROM_DATA(rom), .DM_RDATA(rdata),
		.DM_RVALID(rvalid), .ACC(acc), .PC(pc), .DUMMY_CYCLE(dummy),
		.TBL_ADDR(tbl_addr), .TBL_BUSY(tbl_busy));
	sra_rom_model #(.PC_W(11), .ROM_W(14)) i_rom (.addr(tbl_addr), .busy(tbl_busy), .data(rom));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic close_out;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk) req <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk) req <= '0;
		#1 chk(16'(rvalid), 16'h0001);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wr(PTR_ADDR, 8'h41);
		rd(PTR_ADDR, 8'h41);
		wr(IAP_ADDR, 8'h5A);
		rd(8'h41, 8'h5A);
		rd(IAP_ADDR, 8'h5A);
		wr(PTR_ADDR, 8'hFF);
		wr(IAP_ADDR, 8'hC3);
		rd(8'hFF, 8'hC3);
		wr(PTR_ADDR, 8'h00);
		wr(IAP_ADDR, 8'h77);
		rd(IAP_ADDR, 8'h00);
		rd(PTR_ADDR, 8'h00);
		rd(8'h41, 8'h5A);
		wr(8'h02, 8'hA5);
		rd(8'h02, 8'h00);
		wr(8'h3F, 8'hA5);
		rd(8'h3F, 8'h00);
		@(posedge clk) begin
			alu_we <= 1'b1;
			alu_res <= 8'h9C;
		end
		@(posedge clk) alu_we <= 1'b0;
		#1 chk({8'h00, acc}, 16'h009C);
		rd(ACC_ADDR, 8'h9C);
		wr(PCL_ADDR, 8'h33);
		chk(16'(dummy), 16'h0001);
		chk({5'h00, pc}, 16'h0033);
		@(posedge clk) pc_step <= 1'b1;
		#1 chk(16'(dummy), 16'h0000);
		repeat (208) @(posedge clk);
		pc_step <= 1'b0;
		#1 chk({5'h00, pc}, 16'h0103);
		wr(PCL_ADDR, 8'h20);
		chk({5'h00, pc}, 16'h0120);
		wr(TABLE_READ_POINTER_ADDR, 8'h12);
		@(posedge clk) begin
			tbl_rd <= 1'b1;
			tbl_dest <= 8'h50;
		end
		@(posedge clk) tbl_rd <= 1'b0;
		#1 chk(16'(tbl_busy), 16'h0001);
		chk({5'h00, tbl_addr}, 16'h0112);
		// page bits do not enter the model word, so it is 384E
		rd(TABLE_READ_HIGH_BYTE_ADDR, 8'h38);
		rd(8'h50, 8'h4E);
		close_out();
	end
	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		close_out();
	end
endmodule
`default_nettype wire
